// ---- logic/wcm_defines.vh ----
// constants for the wake-up clock masking block
`ifndef WCM_DEFINES_VH
`define WCM_DEFINES_VH

// clock and timing figures
`define WCM_CLK_PERIOD_NS 5
`define WCM_LONG_MASK_NS 150000
`define WCM_SHORT_MASK_NS 2000
`define WCM_OVERSHOOT_NS 6000
`define WCM_TMR_W 15

// post-wake wait counts per core level, in main clock cycles
`define WCM_WAIT_LVL0 7'h20
`define WCM_WAIT_LVL1 7'h30
`define WCM_WAIT_LVL2 7'h40
`define WCM_WAIT_LVL3 7'h50

// oscillator thresholds per core level, units of 100 kHz
`define WCM_FTHR_LVL0 8'h32
`define WCM_FTHR_LVL1 8'h4b
`define WCM_FTHR_LVL2 8'h64
`define WCM_FTHR_LVL3 8'h7d

// register indices
`define WCM_ADDR_W 3
`define WCM_REG_CTRL 3'h0
`define WCM_REG_CLK_DIV 3'h1
`define WCM_REG_CLK_REQ 3'h2
`define WCM_REG_OSC_FREQ 3'h3
`define WCM_REG_STATUS 3'h4

// control register fields
`define WCM_CTRL_SUP_EN 0
`define WCM_CTRL_MON_EN 1
`define WCM_CTRL_SUP_FP 2
`define WCM_CTRL_MON_FP 3
`define WCM_CTRL_LVL_LO 4
`define WCM_CTRL_LVL_HI 5
`define WCM_CTRL_MAIN_DCO 6
`define WCM_CTRL_SUB_XT2 7
`define WCM_CTRL_RST 8'h4f

// divider field and reset values
`define WCM_DIV_W 3
`define WCM_DIV_BY2 3'h1
`define WCM_DIV_RST 3'h0
`define WCM_DIV_MAX 3'h5
`define WCM_FREQ_RST 8'h00

// status register fields
`define WCM_ST_MASK 2
`define WCM_ST_OVER 3
`define WCM_ST_HAZ 4
`define WCM_ST_RESTORE 5
`define WCM_ST_DIVWARN 6
`define WCM_ST_MODE_B 7

// power states
`define WCM_S_ACTIVE 2'h0
`define WCM_S_SLEEP 2'h1
`define WCM_S_MASK 2'h2

`endif

// ---- logic/wcm_timer.v ----
// one-shot down counter used for the wake-up mask and overshoot windows
`timescale 1ns/1ps
`default_nettype none
module wcm_timer #(
   parameter W = 15
) (
   input wire ref_clk_in,
   input wire rstn_in,
   input wire start_in,
   input wire [W-1:0] load_in,
   output wire busy_out
);
   reg [W-1:0] cnt_q;
   reg [W-1:0] cnt_d;

   // load on start, otherwise count down to zero and stop
   always @* begin
      cnt_d = cnt_q;
      if (start_in) begin
         cnt_d = load_in;
      end else if (cnt_q != {W{1'b0}}) begin
         cnt_d = cnt_q - {{(W-1){1'b0}}, 1'b1};
      end
   end

   always @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         cnt_q <= {W{1'b0}};
      end else begin
         cnt_q <= cnt_d;
      end
   end

   // busy for exactly load_in cycles after the start edge
   assign busy_out = (cnt_q != {W{1'b0}});
endmodule // wcm_timer
`default_nettype wire

// ---- logic/wcm_wakeup_mask.v ----
// wake-up clock masking for exit from the two deep sleep modes
// Operation
// - normal-perf supervision masks cpu 150 us
// - both off or both full-perf: 2 us
// - hazard: short mask with oscillator main clock above level threshold
// - oscillator overshoots up to 6 us after wake
// - subsystem clock never masked during wake-up
//
// Strobed register access and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "wcm_defines.vh"
module wcm_wakeup_mask #(
   parameter LONG_MASK_CYC = `WCM_LONG_MASK_NS / `WCM_CLK_PERIOD_NS,
   parameter SHORT_MASK_CYC = `WCM_SHORT_MASK_NS / `WCM_CLK_PERIOD_NS,
   parameter OVERSHOOT_CYC = `WCM_OVERSHOOT_NS / `WCM_CLK_PERIOD_NS
) (
   input wire ref_clk_in,
   input wire rstn_in,
   input wire [`WCM_ADDR_W-1:0] reg_addr_in,
   input wire [7:0] reg_wdata_in,
   input wire reg_wr_in,
   input wire reg_rd_in,
   output wire [7:0] reg_rdata_out,
   input wire sleep_a_req_in,
   input wire sleep_b_req_in,
   input wire wake_event_in,
   output wire cpu_clk_en_out,
   output wire subsystem_clock_en_out,
   output wire osc_overshoot_out,
   output wire subsystem_overshoot_out,
   output wire main_out_of_spec_out
);
   ////////////////////////////////////////////////////////////////////////
   // registers and state
   reg [7:0] ctrl_q;
   reg [`WCM_DIV_W-1:0] div_q;
   reg req_en_q;
   reg [7:0] freq_q;
   reg div_warn_q;
   reg mode_b_q;
   reg [1:0] state_q;
   reg [1:0] state_d;
   reg [7:0] rdata_q;
   reg [4:0] div_cnt_q;
   reg cpu_en_q;
   reg sub_en_q;
   reg [6:0] post_cnt_q;
   reg wake_s1_q;
   reg wake_s2_q;
   reg wake_s3_q;
   reg wake_lvl_q;
   reg [7:0] freq_thr;
   reg [6:0] wait_cnt;
   reg [7:0] rd_mux;

   wire sup_en;
   wire mon_en;
   wire sup_fp;
   wire mon_fp;
   wire [1:0] core_lvl;
   wire main_dco;
   wire sub_xt2;
   wire short_mode;
   wire hazard;
   wire [4:0] div_mask;
   wire div_hit;
   wire enter_sleep;
   wire wake_go;
   wire mask_busy;
   wire over_busy;
   wire restore_ok;
   wire div_warn_set;
   wire div_warn_clr;
   wire [`WCM_TMR_W-1:0] mask_load;

   ////////////////////////////////////////////////////////////////////////
   // control field decode
   assign sup_en = ctrl_q[`WCM_CTRL_SUP_EN];
   assign mon_en = ctrl_q[`WCM_CTRL_MON_EN];
   assign sup_fp = ctrl_q[`WCM_CTRL_SUP_FP];
   assign mon_fp = ctrl_q[`WCM_CTRL_MON_FP];
   assign core_lvl = ctrl_q[`WCM_CTRL_LVL_HI:`WCM_CTRL_LVL_LO];
   assign main_dco = ctrl_q[`WCM_CTRL_MAIN_DCO];
   assign sub_xt2 = ctrl_q[`WCM_CTRL_SUB_XT2];

   // short mask only when both off or both fast; mixed stays long (safe)
   assign short_mode = (!sup_en && !mon_en) || (sup_fp && mon_fp);
   assign mask_load = short_mode ?
      SHORT_MASK_CYC[`WCM_TMR_W-1:0] :
      LONG_MASK_CYC[`WCM_TMR_W-1:0];

   // per-level thresholds and post-wake wait counts
   always @* begin
      case (core_lvl)
         2'h0: begin
            freq_thr = `WCM_FTHR_LVL0;
            wait_cnt = `WCM_WAIT_LVL0;
         end
         2'h1: begin
            freq_thr = `WCM_FTHR_LVL1;
            wait_cnt = `WCM_WAIT_LVL1;
         end
         2'h2: begin
            freq_thr = `WCM_FTHR_LVL2;
            wait_cnt = `WCM_WAIT_LVL2;
         end
         default: begin
            freq_thr = `WCM_FTHR_LVL3;
            wait_cnt = `WCM_WAIT_LVL3;
         end
      endcase
   end

   // short mask is only unsafe with a fast oscillator-fed main clock
   assign hazard = short_mode && main_dco && (freq_q > freq_thr);

   ////////////////////////////////////////////////////////////////////////
   // wake pin synchroniser: level moves once stages two and three agree
   always @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         wake_s1_q <= 1'b0;
         wake_s2_q <= 1'b0;
         wake_s3_q <= 1'b0;
         wake_lvl_q <= 1'b0;
      end else begin
         wake_s1_q <= wake_event_in;
         wake_s2_q <= wake_s1_q;
         wake_s3_q <= wake_s2_q;
         if (wake_s2_q == wake_s3_q) begin
            wake_lvl_q <= wake_s3_q;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // power state machine
   assign enter_sleep = (state_q == `WCM_S_ACTIVE) &&
      (sleep_a_req_in || sleep_b_req_in);
   assign wake_go = (state_q == `WCM_S_SLEEP) && wake_lvl_q;

   always @* begin
      case (state_q)
         `WCM_S_ACTIVE: begin
            state_d = enter_sleep ? `WCM_S_SLEEP : `WCM_S_ACTIVE;
         end
         `WCM_S_SLEEP: begin
            state_d = wake_go ? `WCM_S_MASK : `WCM_S_SLEEP;
         end
         `WCM_S_MASK: begin
            // release only when the wake-started count has run out
            state_d = mask_busy ? `WCM_S_MASK : `WCM_S_ACTIVE;
         end
         default: begin
            state_d = `WCM_S_ACTIVE;
         end
      endcase
   end

   always @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         state_q <= `WCM_S_ACTIVE;
         mode_b_q <= 1'b0;
      end else begin
         state_q <= state_d;
         if (enter_sleep) begin
            mode_b_q <= sleep_b_req_in;
         end
      end
   end

   // mask window, loaded on the wake edge
   wcm_timer #(
      .W(`WCM_TMR_W)
   ) u_mask_tmr (
      .ref_clk_in(ref_clk_in),
      .rstn_in(rstn_in),
      .start_in(wake_go),
      .load_in(mask_load),
      .busy_out(mask_busy)
   );

   // oscillator overshoot window after every deep sleep exit
   wcm_timer #(
      .W(`WCM_TMR_W)
   ) u_over_tmr (
      .ref_clk_in(ref_clk_in),
      .rstn_in(rstn_in),
      .start_in(wake_go),
      .load_in(OVERSHOOT_CYC[`WCM_TMR_W-1:0]),
      .busy_out(over_busy)
   );

   ////////////////////////////////////////////////////////////////////////
   // main clock divider: divide by two to the field, capped at the max
   assign div_mask = (div_q > `WCM_DIV_MAX) ? 5'h1f :
      ((5'h01 << div_q) - 5'h01);
   assign div_hit = ((div_cnt_q & div_mask) == div_mask);

   // cpu enable low outside active; subsystem follows request in sleep
   always @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         div_cnt_q <= 5'h00;
         cpu_en_q <= 1'b0;
         sub_en_q <= 1'b0;
      end else begin
         div_cnt_q <= div_cnt_q + 5'h01;
         cpu_en_q <= div_hit && (state_d == `WCM_S_ACTIVE);
         // the mask state does not hold the subsystem clock back
         sub_en_q <= (state_d != `WCM_S_SLEEP) || req_en_q;
      end
   end

   assign cpu_clk_en_out = cpu_en_q;
   assign subsystem_clock_en_out = sub_en_q;

   ////////////////////////////////////////////////////////////////////////
   // post-wake cycle count so software can see when the divider may go
   always @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         post_cnt_q <= 7'h7f;
      end else if (wake_go) begin
         post_cnt_q <= 7'h00;
      end else if (cpu_en_q && (post_cnt_q != 7'h7f)) begin
         post_cnt_q <= post_cnt_q + 7'h01;
      end
   end

   assign restore_ok = (post_cnt_q >= wait_cnt);

   ////////////////////////////////////////////////////////////////////////
   // overshoot exposure flags
   assign osc_overshoot_out = over_busy;
   // crystal-fed subsystem clock never sees the overshoot
   assign subsystem_overshoot_out = over_busy && !sub_xt2 && sub_en_q;
   // divide-by-two keeps the running main clock inside its range
   assign main_out_of_spec_out = over_busy && main_dco && cpu_en_q &&
      (div_q == `WCM_DIV_RST);

   ////////////////////////////////////////////////////////////////////////
   // register writes; warning is sticky and a new event beats the clear
   assign div_warn_set = enter_sleep && hazard && (div_q != `WCM_DIV_BY2);
   assign div_warn_clr = reg_wr_in && (reg_addr_in == `WCM_REG_STATUS) &&
      reg_wdata_in[`WCM_ST_DIVWARN];

   always @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         ctrl_q <= `WCM_CTRL_RST;
         div_q <= `WCM_DIV_RST;
         req_en_q <= 1'b1;
         freq_q <= `WCM_FREQ_RST;
         div_warn_q <= 1'b0;
      end else begin
         if (reg_wr_in && (reg_addr_in == `WCM_REG_CTRL)) begin
            ctrl_q <= reg_wdata_in;
         end
         if (reg_wr_in && (reg_addr_in == `WCM_REG_CLK_DIV)) begin
            div_q <= reg_wdata_in[`WCM_DIV_W-1:0];
         end
         if (reg_wr_in && (reg_addr_in == `WCM_REG_CLK_REQ)) begin
            req_en_q <= reg_wdata_in[0];
         end
         if (reg_wr_in && (reg_addr_in == `WCM_REG_OSC_FREQ)) begin
            freq_q <= reg_wdata_in;
         end
         if (div_warn_set) begin
            div_warn_q <= 1'b1;
         end else if (div_warn_clr) begin
            div_warn_q <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read mux; unmapped indices read as zero
   always @* begin
      case (reg_addr_in)
         `WCM_REG_CTRL: begin
            rd_mux = ctrl_q;
         end
         `WCM_REG_CLK_DIV: begin
            rd_mux = {5'h00, div_q};
         end
         `WCM_REG_CLK_REQ: begin
            rd_mux = {7'h00, req_en_q};
         end
         `WCM_REG_OSC_FREQ: begin
            rd_mux = freq_q;
         end
         `WCM_REG_STATUS: begin
            rd_mux = {mode_b_q, div_warn_q, restore_ok, hazard, over_busy,
               (state_q == `WCM_S_MASK), state_q};
         end
         default: begin
            rd_mux = 8'h00;
         end
      endcase
   end

   // data stands only in the cycle after the read strobe
   always @(posedge ref_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rdata_q <= 8'h00;
      end else if (reg_rd_in) begin
         rdata_q <= rd_mux;
      end else begin
         rdata_q <= 8'h00;
      end
   end

   assign reg_rdata_out = rdata_q;
endmodule // wcm_wakeup_mask
`default_nettype wire

// ---- verif/tb_wcm_wakeup_mask.sv ----
// self-checking testbench for the wake-up clock masking block
`timescale 1ns/1ps
`default_nettype none
`include "wcm_defines.vh"
module tb_wcm_wakeup_mask;
localparam LONG = 40;
localparam SHORT = 8;
localparam OVER = 16;
logic ref_clk_in = 1'b0;
logic rstn_in = 1'b0;
logic [2:0] addr = 3'h0;
logic [7:0] wdata = 8'h00;
logic wr = 1'b0;
logic rd = 1'b0;
logic sleep_a = 1'b0;
logic sleep_b = 1'b0;
logic wake = 1'b0;
wire [7:0] rdata;
wire cpu_en;
wire sub_en;
wire osc_ov;
wire sub_ov;
wire main_oos;
wire [15:0] oos_hits;
wire [15:0] gap;
wire [15:0] over_len;
wire [15:0] sub_hits;
logic [7:0] v;
int mismatches = 0;
int comparisons = 0;
always #2.5 ref_clk_in = ~ref_clk_in;
wcm_wakeup_mask #(.LONG_MASK_CYC(LONG), .SHORT_MASK_CYC(SHORT),
   .OVERSHOOT_CYC(OVER)) dut (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
   .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
   .reg_rd_in(rd), .reg_rdata_out(rdata), .sleep_a_req_in(sleep_a),
   .sleep_b_req_in(sleep_b), .wake_event_in(wake), .cpu_clk_en_out(cpu_en),
   .subsystem_clock_en_out(sub_en), .osc_overshoot_out(osc_ov),
   .subsystem_overshoot_out(sub_ov), .main_out_of_spec_out(main_oos));
wcm_cpu_model cpu (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in),
   .cpu_clk_en_in(cpu_en), .osc_overshoot_in(osc_ov),
   .sub_overshoot_in(sub_ov), .main_oos_in(main_oos), .gap_out(gap),
   .over_len_out(over_len), .sub_hits_out(sub_hits),
   .oos_hits_out(oos_hits));
////////////////////////////////////////////////////////////////////////////
task automatic check(input logic [15:0] seen, input logic [15:0] exp);
   comparisons++;
   if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
   end
endtask
task automatic give_verdict;
   $display("mismatches %0d comparisons %0d", mismatches, comparisons);
   if (mismatches == 0 && comparisons > 0)
      $display("RESULT: PASS");
   else
      $display("RESULT: FAIL");
   $finish;
endtask
task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
   @(posedge ref_clk_in);
   addr <= a;
   wdata <= d;
   wr <= 1'b1;
   @(posedge ref_clk_in);
   wr <= 1'b0;
endtask
// read data is valid only in the cycle after the strobe
task automatic rd_reg(input logic [2:0] a);
   @(posedge ref_clk_in);
   addr <= a;
   rd <= 1'b1;
   @(posedge ref_clk_in);
   rd <= 1'b0;
   #1 v = rdata;
endtask
// sleep, wake, then wait until the cpu runs and the overshoot has ended
task automatic sleep_wake(input logic mode_b, input logic exp_sub);
   @(posedge ref_clk_in);
   sleep_a <= !mode_b;
   sleep_b <= mode_b;
   @(posedge ref_clk_in);
   sleep_a <= 1'b0;
   sleep_b <= 1'b0;
   repeat (3) @(posedge ref_clk_in);
   // with the request enable cleared the subsystem clock stops in sleep
   check(sub_en, exp_sub);
   wake <= 1'b1;
   for (int i = 0; i < 20 && !osc_ov; i++) @(posedge ref_clk_in);
   wake <= 1'b0;
   for (int i = 0; i < 100 && !cpu_en; i++) @(posedge ref_clk_in);
   repeat (OVER + 4) @(posedge ref_clk_in);
endtask
////////////////////////////////////////////////////////////////////////////
task automatic t_reset;
   // no wake pending after reset, so the divider restore is allowed
   logic [7:0] exp [6] = '{8'h4f, 8'h00, 8'h01, 8'h00, 8'h20, 8'h00};
   for (int i = 0; i < 6; i++) begin
      rd_reg(i[2:0]);
      check(v, exp[i]);
   end
endtask
task automatic t_levels;
   logic [7:0] thr [4] = '{`WCM_FTHR_LVL0, `WCM_FTHR_LVL1, `WCM_FTHR_LVL2,
      `WCM_FTHR_LVL3};
   for (int l = 0; l < 4; l++) begin
      wr_reg(3'h0, 8'h4f | (l[7:0] << 4));
      wr_reg(3'h3, thr[l] + 8'h01);
      rd_reg(3'h4);
      check(v[4], 1'b1);
      wr_reg(3'h3, thr[l]);
      rd_reg(3'h4);
      check(v[4], 1'b0);
   end
endtask
task automatic t_short;
   wr_reg(3'h0, 8'h4f);
   wr_reg(3'h3, 8'h33);
   wr_reg(3'h1, 8'h01);
   sleep_wake(1'b0, 1'b1);
   check(gap + 16'h0001 >= SHORT && gap <= SHORT + 2, 1'b1);
   check(over_len, OVER);
   check(sub_hits, OVER);
   check(oos_hits, 16'h0000);
   rd_reg(3'h4);
   check({v[6], v[5]}, 2'b00);
   repeat (80) @(posedge ref_clk_in);
   rd_reg(3'h4);
   check(v[5], 1'b1);
   wr_reg(3'h1, 8'h00);
endtask
task automatic t_warn;
   sleep_wake(1'b1, 1'b1);
   // undivided clock runs fast for the overshoot left after the short mask
   check(oos_hits, OVER - SHORT - 1);
   rd_reg(3'h4);
   check(v[7:6], 2'b11);
   wr_reg(3'h4, 8'h40);
   rd_reg(3'h4);
   check(v[6], 1'b0);
endtask
task automatic t_long_xtal;
   wr_reg(3'h0, 8'hc3);
   wr_reg(3'h2, 8'h00);
   sleep_wake(1'b0, 1'b0);
   check(gap + 16'h0001 >= LONG && gap <= LONG + 2, 1'b1);
   check(oos_hits, 16'h0000);
   check(sub_hits, 16'h0000);
   check(over_len, OVER);
endtask
initial begin
   repeat (3) @(posedge ref_clk_in);
   rstn_in <= 1'b1;
   t_reset();
   t_levels();
   t_short();
   t_warn();
   t_long_xtal();
   give_verdict();
end
// watchdog sized well above the few hundred cycles the tests need
initial begin
   repeat (20000) @(posedge ref_clk_in);
   mismatches++;
   give_verdict();
end
endmodule // tb_wcm_wakeup_mask
`default_nettype wire

// ---- verif/wcm_cpu_model.sv ----
// cpu and peripheral model that measures what it sees after a wake
`timescale 1ns/1ps
`default_nettype none
module wcm_cpu_model (
   input wire logic ref_clk_in,
   input wire logic rstn_in,
   input wire logic cpu_clk_en_in,
   input wire logic osc_overshoot_in,
   input wire logic sub_overshoot_in,
   input wire logic main_oos_in,
   output logic [15:0] gap_out,
   output logic [15:0] over_len_out,
   output logic [15:0] sub_hits_out,
   output logic [15:0] oos_hits_out
);
logic ov_q;
logic wait_q;
// cpu stalls until its enable returns; peripherals tick on every fast edge
always @(posedge ref_clk_in or negedge rstn_in) begin
   if (!rstn_in) begin
      ov_q <= 1'b0;
      wait_q <= 1'b0;
      gap_out <= 16'h0000;
      over_len_out <= 16'h0000;
      sub_hits_out <= 16'h0000;
      oos_hits_out <= 16'h0000;
   end else begin
      ov_q <= osc_overshoot_in;
      if (osc_overshoot_in && !ov_q) begin
         wait_q <= 1'b1;
         gap_out <= 16'h0001;
         over_len_out <= 16'h0001;
         sub_hits_out <= {15'h0000, sub_overshoot_in};
         oos_hits_out <= {15'h0000, main_oos_in};
      end else begin
         // cycles in which the cpu runs on an undivided fast clock
         if (main_oos_in)
            oos_hits_out <= oos_hits_out + 16'h0001;
         if (osc_overshoot_in)
            over_len_out <= over_len_out + 16'h0001;
         if (sub_overshoot_in)
            sub_hits_out <= sub_hits_out + 16'h0001;
         if (wait_q && cpu_clk_en_in)
            wait_q <= 1'b0;
         else if (wait_q)
            gap_out <= gap_out + 16'h0001;
      end
   end
end
endmodule // wcm_cpu_model
`default_nettype wire

// ---- verif/wcm_wakeup_mask_sva.sv ----
// assertion checker bound to the wake-up clock masking block
`timescale 1ns/1ps
`default_nettype none
module wcm_wakeup_mask_sva #(
   parameter LONG_MASK_CYC = 40,
   parameter SHORT_MASK_CYC = 8,
   parameter OVERSHOOT_CYC = 16
) (
   input wire logic ref_clk_in,
   input wire logic rstn_in,
   input wire logic [2:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic cpu_clk_en_out,
   input wire logic subsystem_clock_en_out,
   input wire logic osc_overshoot_out,
   input wire logic subsystem_overshoot_out,
   input wire logic main_out_of_spec_out
);
default clocking @(posedge ref_clk_in); endclocking
default disable iff (!rstn_in);
logic [7:0] ctrl_q;
logic [2:0] div_q;
logic [15:0] ov_cnt_q;
logic [15:0] gap_q;
logic gap_run_q;
logic short_w;
logic [15:0] len_w;
// mixed supervisor settings fall back to the long mask
assign short_w = (!ctrl_q[0] && !ctrl_q[1]) || (ctrl_q[2] && ctrl_q[3]);
assign len_w = short_w ? 16'(SHORT_MASK_CYC) : 16'(LONG_MASK_CYC);
// register shadows and window counters, seen only from the ports
always @(posedge ref_clk_in or negedge rstn_in) begin
   if (!rstn_in) begin
      ctrl_q <= 8'h4f;
      div_q <= 3'h0;
      ov_cnt_q <= 16'h0000;
      gap_q <= 16'h0000;
      gap_run_q <= 1'b0;
   end else begin
      if (reg_wr_in && reg_addr_in == 3'h0)
         ctrl_q <= reg_wdata_in;
      if (reg_wr_in && reg_addr_in == 3'h1)
         div_q <= reg_wdata_in[2:0];
      ov_cnt_q <= osc_overshoot_out ? ov_cnt_q + 16'h0001 : 16'h0000;
      if (osc_overshoot_out && ov_cnt_q == 16'h0000) begin
         gap_run_q <= 1'b1;
         gap_q <= 16'h0001;
      end else if (gap_run_q && cpu_clk_en_out)
         gap_run_q <= 1'b0;
      else if (gap_run_q)
         gap_q <= gap_q + 16'h0001;
   end
end
////////////////////////////////////////////////////////////////////////////
ov_len_a: assert property ($fell(osc_overshoot_out) |->
   ov_cnt_q == OVERSHOOT_CYC) else $error("overshoot length wrong");
ov_bound_a: assert property (ov_cnt_q <= OVERSHOOT_CYC)
   else $error("overshoot too long");
mask_len_a: assert property (gap_run_q && cpu_clk_en_out |->
   gap_q + 16'h0001 >= len_w && gap_q <= len_w + 16'h0002)
   else $error("cpu mask length wrong");
mask_bound_a: assert property (gap_run_q |-> gap_q <= len_w + 16'h0002)
   else $error("cpu mask overran");
long_hold_a: assert property ($rose(osc_overshoot_out) && !short_w |->
   !cpu_clk_en_out [*8]) else $error("cpu ran during long mask");
sub_run_a: assert property ($rose(osc_overshoot_out) |->
   ##1 subsystem_clock_en_out [*4]) else $error("subsystem clock masked");
sub_ov_a: assert property (subsystem_overshoot_out ==
   (osc_overshoot_out && !ctrl_q[7] && subsystem_clock_en_out))
   else $error("subsystem overshoot flag wrong");
main_spec_a: assert property (main_out_of_spec_out ==
   (osc_overshoot_out && ctrl_q[6] && cpu_clk_en_out && div_q == 3'h0))
   else $error("main clock spec flag wrong");
endmodule // wcm_wakeup_mask_sva
bind wcm_wakeup_mask wcm_wakeup_mask_sva #(.LONG_MASK_CYC(LONG_MASK_CYC),
   .SHORT_MASK_CYC(SHORT_MASK_CYC), .OVERSHOOT_CYC(OVERSHOOT_CYC)) u_sva (
   .ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .reg_addr_in(reg_addr_in),
   .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
   .cpu_clk_en_out(cpu_clk_en_out),
   .subsystem_clock_en_out(subsystem_clock_en_out),
   .osc_overshoot_out(osc_overshoot_out),
   .subsystem_overshoot_out(subsystem_overshoot_out),
   .main_out_of_spec_out(main_out_of_spec_out));
`default_nettype wire
